// ---- verilog/msc_map.svh ----
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define MSC_OFF_STATUS      8'h00
`define MSC_OFF_VERSION     8'h04
`define MSC_OFF_CONFIG      8'h08
`define MSC_OFF_STATUS_CLR  8'h0C
`define MSC_OFF_IRQ_STATUS  8'h10
`define MSC_OFF_IRQ_CLEAR   8'h14
`define MSC_OFF_IRQ_ENABLE  8'h18
`define MSC_OFF_PHASE       8'h1C

// ****************************************
// Status word fields
// ****************************************
`define MSC_ST_ACTIVE_POWER_SIGN      4
`define MSC_ST_OVER_POW     3
`define MSC_ST_OVER_CUR     2
`define MSC_ST_SURGE        1
`define MSC_ST_SAG          0

// ****************************************
// Configuration word fields
// ****************************************
`define MSC_CF_VGAIN_HI     29
`define MSC_CF_VGAIN_LO     27
`define MSC_CF_IGAIN_HI     26
`define MSC_CF_IGAIN_LO     24
`define MSC_CF_BAUD_HI      15
`define MSC_CF_BAUD_LO      13
`define MSC_CF_ZC_INV       12
`define MSC_CF_ZC_PULSE     11
`define MSC_CF_ZC_DIS       10
`define MSC_CF_SINGLE_WIRE  8
`define MSC_CF_TEMP_COMP    7
`define MSC_CF_RST_HI       6
`define MSC_CF_RST_LO       5
`define MSC_CF_SHDN_HI      4
`define MSC_CF_SHDN_LO      3
`define MSC_CF_REF_DIS      2
`define MSC_CF_PULSE_OUT    1
`define MSC_CF_ENERGY       0

`define MSC_CFG_RESET       32'h0300_8000
`define MSC_CFG_WMASK       32'h3F00_FDFF
`define MSC_BAUD_RESET      3'h4
`define MSC_GAIN_MAX_CODE   3'h5

// ****************************************
// Timing
// ****************************************
`define MSC_CLK_MHZ         100
`define MSC_SEQ_HOLD_NS     1000

`endif

// ---- verilog/msc_pkg.sv ----
package msc_pkg;

	// ****************************************
	// Serial soft-reset sequencer states
	// ****************************************
	typedef enum logic [1:0]
	{
		MSC_SEQ_IDLE  = 2'b00,
		MSC_SEQ_CUR   = 2'b01,
		MSC_SEQ_VOLT  = 2'b10
	} msc_seq_t;

	typedef logic [2:0] msc_gain_t;

endpackage : msc_pkg

// ---- verilog/msc_sticky.sv ----
`timescale 1ns/1ps

module msc_sticky
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);

	// ****************************************
	// Sticky bits, set beats clear
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			q <= '0;
		else
			q <= (q & ~clr) | set;
	end

endmodule : msc_sticky

// ---- verilog/msc_regs.sv ----
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "msc_map.svh"

module msc_regs
#(
	parameter logic [15:0] VERSION_CODE = 16'h2401, // Arbitrary value
	parameter int          ADC_W        = 24
)
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output logic                   irq,
	input  wire logic              meas_valid,
	input  wire logic [31:0]       active_power,
	input  wire logic [31:0]       rms_current,
	input  wire logic [15:0]       rms_voltage,
	input  wire logic [31:0]       over_power_limit,
	input  wire logic [31:0]       over_current_limit,
	input  wire logic [15:0]       sag_limit,
	input  wire logic [15:0]       surge_limit,
	input  wire logic              power_up_load,
	input  wire logic [ADC_W-1:0]  adc_v_raw,
	input  wire logic [ADC_W-1:0]  adc_i_raw,
	output logic      [ADC_W-1:0]  adc_v_data,
	output logic      [ADC_W-1:0]  adc_i_data,
	output logic                   adc_v_power_on,
	output logic                   adc_i_power_on,
	output msc_pkg::msc_gain_t     voltage_gain_sel,
	output msc_pkg::msc_gain_t     current_gain_sel,
	output logic      [2:0]        voltage_gain_log2,
	output logic      [2:0]        current_gain_log2,
	output logic      [2:0]        baud_sel,
	output logic                   zero_cross_invert,
	output logic                   zero_cross_pulse_mode,
	output logic                   zero_cross_out_disable,
	output logic                   single_wire_enable,
	output logic                   temp_comp_enable,
	output logic                   internal_ref_disable,
	output logic                   pulse_out_enable,
	output logic                   energy_accum_enable,
	output logic                   energy_accum_clear
);

	localparam int SEQ_CYC = (`MSC_SEQ_HOLD_NS * `MSC_CLK_MHZ + 999) / 1000;

	// ****************************************
	// Declarations
	// ****************************************
	logic [31:0]            config_r;
	logic [31:0]            phase_r;
	logic [31:0]            rdata_nxt;
	logic                   sign_r;
	logic                   over_pow_r;
	logic                   over_cur_r;
	logic [1:0]             latch_q;
	logic [1:0]             latch_set;
	logic [1:0]             latch_clr;
	logic [3:0]             irq_q;
	logic [3:0]             irq_set;
	logic [3:0]             irq_clr;
	logic [3:0]             irq_en_r;
	logic [15:0]            status_word;
	logic [31:0]            power_mag;
	logic                   pow_over;
	logic                   cur_over;
	logic                   surge_hit;
	logic                   sag_hit;
	logic                   wr_config;
	logic                   wr_phase;
	logic                   phase_same;
	logic                   v_soft_rst;
	logic                   i_soft_rst;
	logic [2:0]             baud_r;
	logic [7:0]             seq_cnt_r;
	msc_pkg::msc_seq_t      seq_r;

	// ****************************************
	// Address decode
	// ****************************************
	assign wr_config  = reg_wr && (reg_addr == `MSC_OFF_CONFIG);
	assign wr_phase   = reg_wr && (reg_addr == `MSC_OFF_PHASE);
	assign phase_same = wr_phase && (reg_wdata == phase_r);

	// ****************************************
	// Measurement comparisons
	// ****************************************
	// Power limit is compared against magnitude so export overloads trip as well
	assign power_mag = active_power[31] ? (32'h0000_0000 - active_power) : active_power;
	assign pow_over  = power_mag > over_power_limit;
	assign cur_over  = rms_current > over_current_limit;
	assign surge_hit = meas_valid && (rms_voltage > surge_limit);
	assign sag_hit   = meas_valid && (rms_voltage < sag_limit);

	always_ff @(posedge clk)
	begin
		if (reset)
			sign_r <= 1'b1;
		else if (meas_valid)
			sign_r <= ~active_power[31];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			over_pow_r <= 1'b0;
		else if (meas_valid)
			over_pow_r <= pow_over;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			over_cur_r <= 1'b0;
		else if (meas_valid)
			over_cur_r <= cur_over;
	end

	// ****************************************
	// Latched surge and sag flags
	// ****************************************
	assign latch_set[`MSC_ST_SURGE] = surge_hit;
	assign latch_set[`MSC_ST_SAG]   = sag_hit;
	assign latch_clr = (reg_wr && (reg_addr == `MSC_OFF_STATUS_CLR)) ? reg_wdata[1:0] : 2'h0;

	msc_sticky
	#(
		.W (2)
	)
	u_latch
	(
		.clk   (clk),
		.reset (reset),
		.set   (latch_set),
		.clr   (latch_clr),
		.q     (latch_q)
	);

	assign status_word = {11'h000, sign_r, over_pow_r, over_cur_r, latch_q};

	// ****************************************
	// Interrupt status, clear and enable
	// ****************************************
	// Bits: 3 over-power rise, 2 over-current rise, 1 surge, 0 sag
	assign irq_set = {meas_valid && pow_over && !over_pow_r,
	                  meas_valid && cur_over && !over_cur_r,
	                  surge_hit,
	                  sag_hit};
	assign irq_clr = (reg_wr && (reg_addr == `MSC_OFF_IRQ_CLEAR)) ? reg_wdata[3:0] : 4'h0;

	msc_sticky
	#(
		.W (4)
	)
	u_irq
	(
		.clk   (clk),
		.reset (reset),
		.set   (irq_set),
		.clr   (irq_clr),
		.q     (irq_q)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
			irq_en_r <= 4'h0;
		else if (reg_wr && (reg_addr == `MSC_OFF_IRQ_ENABLE))
			irq_en_r <= reg_wdata[3:0];
	end

	assign irq = |(irq_q & irq_en_r);

	// ****************************************
	// Configuration word
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			config_r <= `MSC_CFG_RESET;
		else if (wr_config)
			config_r <= reg_wdata & `MSC_CFG_WMASK;
	end

	// Baud rate follows the stored field only on a power-up load, never mid-session
	always_ff @(posedge clk)
	begin
		if (reset)
			baud_r <= `MSC_BAUD_RESET;
		else if (power_up_load)
			baud_r <= config_r[`MSC_CF_BAUD_HI:`MSC_CF_BAUD_LO];
	end

	assign baud_sel = baud_r;

	// ****************************************
	// Gain selection
	// ****************************************
	function automatic logic [2:0] gain_log2(input msc_pkg::msc_gain_t code);
		if (code > `MSC_GAIN_MAX_CODE)
			gain_log2 = 3'h0;
		else
			gain_log2 = code;
	endfunction : gain_log2

	assign voltage_gain_sel  = config_r[`MSC_CF_VGAIN_HI:`MSC_CF_VGAIN_LO];
	assign current_gain_sel  = config_r[`MSC_CF_IGAIN_HI:`MSC_CF_IGAIN_LO];
	assign voltage_gain_log2 = gain_log2(voltage_gain_sel);
	assign current_gain_log2 = gain_log2(current_gain_sel);

	// ****************************************
	// Miscellaneous controls
	// ****************************************
	assign zero_cross_invert      = config_r[`MSC_CF_ZC_INV];
	assign zero_cross_pulse_mode  = config_r[`MSC_CF_ZC_PULSE];
	assign zero_cross_out_disable = config_r[`MSC_CF_ZC_DIS];
	assign single_wire_enable     = config_r[`MSC_CF_SINGLE_WIRE];
	assign temp_comp_enable       = config_r[`MSC_CF_TEMP_COMP];
	assign internal_ref_disable   = config_r[`MSC_CF_REF_DIS];
	assign pulse_out_enable       = config_r[`MSC_CF_PULSE_OUT];
	assign energy_accum_enable    = config_r[`MSC_CF_ENERGY];
	assign energy_accum_clear     = ~config_r[`MSC_CF_ENERGY];

	// ****************************************
	// Phase register and serial soft reset
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (reset)
			phase_r <= 32'h0000_0000;
		else if (wr_phase)
			phase_r <= reg_wdata;
	end

	// A repeat write during a running sequence is ignored so each converter gets its full hold
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			seq_r     <= msc_pkg::MSC_SEQ_IDLE;
			seq_cnt_r <= 8'h00;
		end
		else
		begin
			case (seq_r)
				msc_pkg::MSC_SEQ_IDLE:
				begin
					if (phase_same)
					begin
						seq_r     <= msc_pkg::MSC_SEQ_CUR;
						seq_cnt_r <= 8'(SEQ_CYC - 1);
					end
				end
				msc_pkg::MSC_SEQ_CUR:
				begin
					if (seq_cnt_r == 8'h00)
					begin
						seq_r     <= msc_pkg::MSC_SEQ_VOLT;
						seq_cnt_r <= 8'(SEQ_CYC - 1);
					end
					else
						seq_cnt_r <= seq_cnt_r - 8'h01;
				end
				msc_pkg::MSC_SEQ_VOLT:
				begin
					if (seq_cnt_r == 8'h00)
						seq_r <= msc_pkg::MSC_SEQ_IDLE;
					else
						seq_cnt_r <= seq_cnt_r - 8'h01;
				end
				default:
				begin
					seq_r     <= msc_pkg::MSC_SEQ_IDLE;
					seq_cnt_r <= 8'h00;
				end
			endcase
		end
	end

	// ****************************************
	// Converter soft reset and shutdown
	// ****************************************
	assign v_soft_rst = config_r[`MSC_CF_RST_HI] || (seq_r == msc_pkg::MSC_SEQ_VOLT);
	assign i_soft_rst = config_r[`MSC_CF_RST_LO] || (seq_r == msc_pkg::MSC_SEQ_CUR);

	// Converter keeps running; only its sample is zeroed
	always_ff @(posedge clk)
	begin
		if (reset)
			adc_v_data <= '0;
		else
			adc_v_data <= v_soft_rst ? '0 : adc_v_raw;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			adc_i_data <= '0;
		else
			adc_i_data <= i_soft_rst ? '0 : adc_i_raw;
	end

	// Power-on gates biases, clock and digital logic of each converter together
	assign adc_v_power_on = ~config_r[`MSC_CF_SHDN_HI];
	assign adc_i_power_on = ~config_r[`MSC_CF_SHDN_LO];

	// ****************************************
	// Read path
	// ****************************************
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		case (reg_addr)
			`MSC_OFF_STATUS:     rdata_nxt = {16'h0000, status_word};
			`MSC_OFF_VERSION:    rdata_nxt = {16'h0000, VERSION_CODE};
			`MSC_OFF_CONFIG:     rdata_nxt = config_r;
			`MSC_OFF_IRQ_STATUS: rdata_nxt = {28'h000_0000, irq_q};
			`MSC_OFF_IRQ_ENABLE: rdata_nxt = {28'h000_0000, irq_en_r};
			`MSC_OFF_PHASE:      rdata_nxt = phase_r;
			default:             rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Read data holds only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= 32'h0000_0000;
	end

endmodule : msc_regs

// ---- verification/msc_regs_monitor.sv ----
`timescale 1ns/1ps
`include "msc_map.svh"

// ****
// Register block checker
// ****
module msc_regs_monitor
#(
	parameter int ADC_W = 24
)
(
	input wire logic               clk,
	input wire logic               reset,
	input wire logic [7:0]         reg_addr,
	input wire logic [31:0]        reg_wdata,
	input wire logic               reg_wr,
	input wire logic [ADC_W-1:0]   adc_v_data,
	input wire logic [ADC_W-1:0]   adc_i_data,
	input wire logic               adc_v_power_on,
	input wire logic               adc_i_power_on,
	input wire msc_pkg::msc_gain_t voltage_gain_sel,
	input wire msc_pkg::msc_gain_t current_gain_sel,
	input wire logic [2:0]         voltage_gain_log2,
	input wire logic [2:0]         current_gain_log2,
	input wire logic [2:0]         baud_sel,
	input wire logic               power_up_load,
	input wire logic               energy_accum_enable,
	input wire logic               energy_accum_clear
);
	logic cfg_wr;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	assign cfg_wr = reg_wr && (reg_addr == `MSC_OFF_CONFIG);

	vgain_decode_a: assert property (voltage_gain_log2 == ((voltage_gain_sel > 3'h5) ? 3'h0 : voltage_gain_sel))
		else $error("voltage gain decode wrong");
	igain_decode_a: assert property (current_gain_log2 == ((current_gain_sel > 3'h5) ? 3'h0 : current_gain_sel))
		else $error("current gain decode wrong");
	gain_write_a: assert property (cfg_wr |=> voltage_gain_sel == $past(reg_wdata[29:27])
		&& current_gain_sel == $past(reg_wdata[26:24])) else $error("gain fields not loaded");
	shutdown_ctl_a: assert property (cfg_wr |=> adc_v_power_on == !$past(reg_wdata[4])
		&& adc_i_power_on == !$past(reg_wdata[3])) else $error("converter power wrong");
	// Two edges: the field lands first, the zeroed sample one edge later
	vsoft_zero_a: assert property (cfg_wr && reg_wdata[6] ##1 !cfg_wr |=> adc_v_data == '0)
		else $error("voltage data not forced to zero");
	isoft_zero_a: assert property (cfg_wr && reg_wdata[5] ##1 !cfg_wr |=> adc_i_data == '0)
		else $error("current data not forced to zero");
	energy_clear_a: assert property (energy_accum_clear == !energy_accum_enable)
		else $error("energy clear not inverse of enable");
	baud_hold_a: assert property (!power_up_load |=> $stable(baud_sel))
		else $error("baud changed without load");
endmodule : msc_regs_monitor

bind msc_regs msc_regs_monitor #(.ADC_W(ADC_W)) i_msc_regs_monitor
(
	.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.adc_v_data(adc_v_data), .adc_i_data(adc_i_data), .adc_v_power_on(adc_v_power_on),
	.adc_i_power_on(adc_i_power_on), .voltage_gain_sel(voltage_gain_sel), .current_gain_sel(current_gain_sel),
	.voltage_gain_log2(voltage_gain_log2), .current_gain_log2(current_gain_log2), .baud_sel(baud_sel),
	.power_up_load(power_up_load), .energy_accum_enable(energy_accum_enable),
	.energy_accum_clear(energy_accum_clear)
);

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`include "msc_map.svh"

module testbench;
	localparam logic [15:0] VER = 16'h1234; // Arbitrary value
	int          seed = 32'h6dd2_a6d3;
	int          mismatches = 0;
	int          samples_checked = 0;
	logic        clk, reset, reg_wr, reg_rd, meas_valid, power_up_load, irq, vpo, ipo;
	logic        zci, zcp, zcd, swe, tce, ird, poe, eae, eac;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, active_power, rms_current, cfg_m, d, p;
	logic [15:0] rms_voltage;
	logic [23:0] adc_v_raw, adc_i_raw, adc_v_data, adc_i_data;
	logic [2:0]  vl, il, baud_sel, baud_m;
	logic [4:0]  st_m;
	logic [3:0]  irq_m, en_m;
	msc_pkg::msc_gain_t vg, ig;

	// ****
	// Design and clock
	// ****
	msc_regs #(.VERSION_CODE(VER), .ADC_W(24)) i_msc_regs
	(
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .meas_valid(meas_valid), .active_power(active_power),
		.rms_current(rms_current), .rms_voltage(rms_voltage), .over_power_limit(32'h0000_03E8),
		.over_current_limit(32'h0000_01F4), .sag_limit(16'h0064), .surge_limit(16'h00C8),
		.power_up_load(power_up_load), .adc_v_raw(adc_v_raw), .adc_i_raw(adc_i_raw), .adc_v_data(adc_v_data),
		.adc_i_data(adc_i_data), .adc_v_power_on(vpo), .adc_i_power_on(ipo), .voltage_gain_sel(vg),
		.current_gain_sel(ig), .voltage_gain_log2(vl), .current_gain_log2(il), .baud_sel(baud_sel),
		.zero_cross_invert(zci), .zero_cross_pulse_mode(zcp), .zero_cross_out_disable(zcd),
		.single_wire_enable(swe), .temp_comp_enable(tce), .internal_ref_disable(ird),
		.pulse_out_enable(poe), .energy_accum_enable(eae), .energy_accum_clear(eac)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****
	// Bus and compare tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask : rd

	// Model of flags and events; over-power events count on the rising edge only
	task automatic meas(input int ap, input int ic, input int vv);
		logic op;
		logic oc;
		@(posedge clk);
		meas_valid <= 1'b1;
		active_power <= ap;
		rms_current <= ic;
		rms_voltage <= vv[15:0];
		@(posedge clk);
		meas_valid <= 1'b0;
		op = ((ap < 0) ? -ap : ap) > 1000;
		oc = ic > 500;
		irq_m |= {op & !st_m[3], oc & !st_m[2], vv > 200, vv < 100};
		st_m = {ap >= 0, op, oc, st_m[1] | (vv > 200), st_m[0] | (vv < 100)};
		rd(`MSC_OFF_STATUS, st_m, "status");
		rd(`MSC_OFF_IRQ_STATUS, irq_m, "irq status");
		chk("irq", |(irq_m & en_m), irq);
	endtask : meas

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// Whole run is a few hundred cycles; this leaves ample margin
	initial
	begin
		#200_000;
		mismatches++;
		complete_run();
	end

	// ****
	// Scenarios
	// ****
	initial
	begin
		{reset, reg_wr, reg_rd, meas_valid, power_up_load} = 5'h10;
		{reg_addr, reg_wdata, active_power, rms_current, rms_voltage} = '0;
		d = $random(seed);
		adc_v_raw = d[23:0];
		d = $random(seed);
		adc_i_raw = d[23:0];
		{st_m, irq_m, en_m, baud_m} = {5'h10, 4'h0, 4'h2, 3'h4};
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(`MSC_OFF_CONFIG, 32'h0300_8000, "config reset");
		rd(`MSC_OFF_VERSION, {16'h0000, VER}, "version");
		wr(`MSC_OFF_VERSION, 32'hFFFF_FFFF);
		rd(`MSC_OFF_VERSION, {16'h0000, VER}, "version");
		wr(`MSC_OFF_STATUS, 32'hFFFF_FFFF);
		rd(`MSC_OFF_STATUS, st_m, "status reset");
		rd(8'h40, 32'h0000_0000, "unmapped");
		chk("baud reset", baud_m, baud_sel);
		for (int i = 0; i < 8; i++)
		begin
			d = $random(seed);
			d[29:24] = {i[2:0], 3'(7 - i)};
			wr(`MSC_OFF_CONFIG, d);
			cfg_m = d & `MSC_CFG_WMASK;
			rd(`MSC_OFF_CONFIG, cfg_m, "config");
			chk("vgain", (i < 6) ? i : 0, vl);
			chk("igain", (7 - i < 6) ? 7 - i : 0, il);
			chk("gain sel", {i[2:0], 3'(7 - i)}, {vg, ig});
			chk("power on", {!d[4], !d[3]}, {vpo, ipo});
			chk("ctrl", {d[12:10], d[8:7], d[2:0], !d[0]}, {zci, zcp, zcd, swe, tce, ird, poe, eae, eac});
			chk("baud held", baud_m, baud_sel);
		end
		@(posedge clk);
		power_up_load <= 1'b1;
		@(posedge clk);
		power_up_load <= 1'b0;
		#1;
		chk("baud load", cfg_m[15:13], baud_sel);
		for (int k = 0; k < 4; k++)
		begin
			wr(`MSC_OFF_CONFIG, 32'h0000_0001 | (k << 5) | (k << 3));
			repeat (2) @(posedge clk);
			#1;
			chk("v data", k[1] ? 24'h00_0000 : adc_v_raw, adc_v_data);
			chk("i data", k[0] ? 24'h00_0000 : adc_i_raw, adc_i_data);
			chk("power", {!k[1], !k[0]}, {vpo, ipo});
		end
		wr(`MSC_OFF_IRQ_ENABLE, 32'h0000_0002);
		meas(-2000, 600, 150);
		meas(5, 10, 250);
		meas(0, 0, 150);
		meas(-3, 0, 50);
		meas(2000, 700, 150);
		wr(`MSC_OFF_STATUS_CLR, 32'h0000_0003);
		st_m[1:0] = 2'b00;
		rd(`MSC_OFF_STATUS, st_m, "status clear");
		wr(`MSC_OFF_IRQ_CLEAR, 32'h0000_000F);
		rd(`MSC_OFF_IRQ_STATUS, 32'h0000_0000, "irq clear");
		rd(`MSC_OFF_IRQ_ENABLE, 32'h0000_0002, "irq enable");
		chk("irq low", 1'b0, irq);
		// Soft reset field must be clear, or the last loop pass keeps both samples at zero
		wr(`MSC_OFF_CONFIG, 32'h0000_0001);
		p = 32'h5A5A_0001;
		wr(`MSC_OFF_PHASE, p);
		rd(`MSC_OFF_PHASE, p, "phase");
		wr(`MSC_OFF_PHASE, p);
		// Current converter is zeroed first, then voltage, each for 100 cycles
		for (int n = 1; n < 204; n++)
		begin
			@(posedge clk);
			#1;
			chk("seq i", (n >= 1 && n <= 100) ? 24'h00_0000 : adc_i_raw, adc_i_data);
			chk("seq v", (n >= 101 && n <= 200) ? 24'h00_0000 : adc_v_raw, adc_v_data);
		end
		complete_run();
	end
endmodule : testbench
